/* design/cpu_memory_bank_mapper.sv */
// Banked data memory mapper with core registers, pointers and program counter.
// Assumes same-clock requests from the execution logic and
// combinational-read program and data arrays.
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module cpu_memory_bank_mapper #(
	parameter int         PROG_AW      = 12,
	parameter int         GPR_BYTES    = 80,
	parameter logic [4:0] TOP_BANK_RST = 5'h1f
) (
	input  wire logic                                clk,
	input  wire logic                                rst_n,
	input  wire logic                                req_valid,
	input  wire logic                                req_write,
	input  wire logic                                req_indirect,
	input  wire logic                                req_ptr_sel,
	input  wire logic [mem_map_pkg::FILE_W-1:0]      req_file_addr,
	input  wire logic [mem_map_pkg::DATA_W-1:0]      req_wdata,
	input  wire logic                                req_load_acc,
	input  wire logic                                req_flags_own,
	input  wire logic                                flag_zero,
	input  wire logic                                nibble_overflow_flag,
	input  wire logic                                flag_carry,
	output logic                                     req_ready_q,
	output logic                                     rsp_valid_q,
	output logic [mem_map_pkg::DATA_W-1:0]           rsp_rdata_q,
	output logic                                     extra_cycle_q,
	output logic [mem_map_pkg::DATA_W-1:0]           acc_q,
	output logic [mem_map_pkg::DATA_W-1:0]           status_q,
	input  wire logic                                pc_advance,
	input  wire logic                                pc_load,
	input  wire logic [mem_map_pkg::PC_W-1:0]        pc_load_value,
	input  wire logic                                irq_enter,
	input  wire logic                                wdt_timeout,
	input  wire logic                                wdt_clear,
	input  wire logic                                sleep_enter,
	output logic [mem_map_pkg::PC_W-1:0]             prog_addr_q,
	input  wire logic [mem_map_pkg::PWORD_W-1:0]     prog_rdata,
	output logic [mem_map_pkg::RAM_AW-1:0]           ram_addr_q,
	output logic                                     ram_we_q,
	output logic [mem_map_pkg::DATA_W-1:0]           ram_wdata_q,
	input  wire logic [mem_map_pkg::DATA_W-1:0]      ram_rdata,
	input  wire logic                                awvalid,
	input  wire logic [mem_map_pkg::AXI_AW-1:0]      awaddr,
	output logic                                     awready,
	input  wire logic                                wvalid,
	input  wire logic [31:0]                         wdata,
	input  wire logic [3:0]                          wstrb,
	output logic                                     wready,
	output logic                                     bvalid,
	output logic [1:0]                               bresp,
	input  wire logic                                bready,
	input  wire logic                                arvalid,
	input  wire logic [mem_map_pkg::AXI_AW-1:0]      araddr,
	output logic                                     arready,
	output logic                                     rvalid,
	output logic [31:0]                              rdata,
	output logic [1:0]                               rresp,
	input  wire logic                                rready
);
	import mem_map_pkg::*;

	localparam logic [6:0] GPR_END = 7'(int'(GPR_FIRST) + GPR_BYTES);

	acc_state_t        state_q, state_d;
	logic [BANK_W-1:0] bank_selector_q, bank_selector_d, top_bank;
	logic [PTR_W-1:0]  ptr0_q, ptr0_d, ptr1_q, ptr1_d, sel_ptr;
	logic [7:0]        pclath_q, pclath_d, intctl_q, intctl_d;
	logic [7:0]        acc_d, status_d, rsp_rdata_d, rd_word, ram_wdata_d;
	logic [PC_W-1:0]   pc_q, pc_d, prog_addr_d;
	logic [RAM_AW-1:0] ram_addr_d;
	logic              req_ready_d, rsp_valid_d, extra_cycle_d, ram_we_d, take;
	logic              dec_prog, dec_hole, dec_core, dec_common;
	logic [BANK_W-1:0] dec_bank;
	logic [FILE_W-1:0] dec_file;
	logic              lat_prog_q, lat_write_q, lat_core_q, lat_hole_q, lat_acc_q, lat_flags_q;
	logic              lat_prog_d, lat_write_d, lat_core_d, lat_hole_d, lat_acc_d, lat_flags_d;
	logic [FILE_W-1:0] lat_file_q, lat_file_d;
	logic [7:0]        lat_wdata_q, lat_wdata_d;
	logic              fin, core_wr;

	function automatic logic [PC_W-1:0] wrap_prog(input logic [PC_W-1:0] a);
		return a & PC_W'((32'h1 << PROG_AW) - 32'h1);
	endfunction : wrap_prog

	function automatic logic [7:0] core_read(input logic [FILE_W-1:0] f);
		case (f)
			A_PCL:     return pc_q[7:0];
			A_STATUS:  return status_q & STATUS_IMPL;
			A_P0L:     return ptr0_q[7:0];
			A_P0H:     return ptr0_q[PTR_W-1:8];
			A_P1L:     return ptr1_q[7:0];
			A_P1H:     return ptr1_q[PTR_W-1:8];
			A_BANK:    return {3'h0, bank_selector_q};
			A_ACC:     return acc_q;
			A_PCLATCH: return {1'b0, pclath_q[PC_W-9:0]};
			A_INTCTL:  return intctl_q;
			default:   return 8'h00;
		endcase
	endfunction : core_read

	// ----------------------------------------------------------------
	// Register bus slave
	// ----------------------------------------------------------------
	mapper_axil_regs #(.TOP_BANK_RST(TOP_BANK_RST)) u_regs (
		.clk        (clk),
		.rst_n      (rst_n),
		.awvalid    (awvalid),
		.awaddr     (awaddr),
		.awready    (awready),
		.wvalid     (wvalid),
		.wdata      (wdata),
		.wstrb      (wstrb),
		.wready     (wready),
		.bvalid     (bvalid),
		.bresp      (bresp),
		.bready     (bready),
		.arvalid    (arvalid),
		.araddr     (araddr),
		.arready    (arready),
		.rvalid     (rvalid),
		.rdata      (rdata),
		.rresp      (rresp),
		.rready     (rready),
		.bank_view  (bank_selector_q),
		.status_view(status_q),
		.pc_view    (pc_q),
		.ptr_view   ({ptr1_q, ptr0_q}),
		.top_bank   (top_bank)
	);

	// ----------------------------------------------------------------
	// Address decode of a new request
	// ----------------------------------------------------------------
	always_comb begin
		sel_ptr  = req_ptr_sel ? ptr1_q : ptr0_q;
		dec_prog = 1'b0;
		dec_hole = 1'b0;
		dec_bank = bank_selector_q;
		dec_file = req_file_addr;
		if (req_indirect) begin
			dec_prog = sel_ptr[PTR_PROG_BIT];
			dec_bank = sel_ptr[FILE_W +: BANK_W];
			dec_file = sel_ptr[FILE_W-1:0];
			dec_hole = !dec_prog && (sel_ptr[PTR_PROG_BIT-1:RAM_AW] != '0);
		end
		dec_core   = dec_file <= CORE_LAST;
		dec_common = dec_file >= COMMON_FIRST;
		if (!dec_core && !dec_common && dec_bank > top_bank) begin
			dec_hole = 1'b1;
		end
		if (dec_file >= GPR_END && !dec_common) begin
			dec_hole = 1'b1;
		end
		if (req_indirect && (dec_file == A_IND0 || dec_file == A_IND1)) begin
			dec_hole = 1'b1;
		end
		if (dec_common) begin
			dec_bank = COMMON_BANK;
		end
	end

	// ----------------------------------------------------------------
	// Access sequencer
	// ----------------------------------------------------------------
	always_comb begin
		take        = req_valid && req_ready_q && state_q == ST_IDLE;
		state_d     = state_q;
		lat_prog_d  = lat_prog_q;
		lat_write_d = lat_write_q;
		lat_core_d  = lat_core_q;
		lat_hole_d  = lat_hole_q;
		lat_acc_d   = lat_acc_q;
		lat_flags_d = lat_flags_q;
		lat_file_d  = lat_file_q;
		lat_wdata_d = lat_wdata_q;
		ram_addr_d  = ram_addr_q;
		ram_wdata_d = ram_wdata_q;
		ram_we_d    = 1'b0;
		rsp_valid_d = 1'b0;
		rsp_rdata_d = rsp_rdata_q;
		extra_cycle_d = 1'b0;
		fin         = 1'b0;
		rd_word     = 8'h00;
		case (state_q)
			ST_IDLE: begin
				if (take) begin
					state_d     = ST_ACCESS;
					lat_prog_d  = dec_prog;
					lat_write_d = req_write;
					lat_core_d  = dec_core && !dec_prog;
					lat_hole_d  = dec_hole;
					lat_acc_d   = req_load_acc;
					lat_flags_d = req_flags_own;
					lat_file_d  = dec_file;
					lat_wdata_d = req_wdata;
					ram_addr_d  = {dec_bank, dec_file};
					ram_wdata_d = req_wdata;
					ram_we_d    = req_write && !dec_prog && !dec_core && !dec_hole;
				end
			end
			ST_ACCESS: begin
				if (lat_prog_q && !lat_write_q) begin
					state_d       = ST_PROG_EXTRA;
					extra_cycle_d = 1'b1;
				end else begin
					state_d = ST_IDLE;
					fin     = 1'b1;
					if (lat_hole_q || lat_write_q) begin
						rd_word = 8'h00;
					end else if (lat_core_q) begin
						rd_word = core_read(lat_file_q);
					end else begin
						rd_word = ram_rdata;
					end
				end
			end
			ST_PROG_EXTRA: begin
				state_d = ST_IDLE;
				fin     = 1'b1;
				rd_word = prog_rdata[DATA_W-1:0];
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		if (fin) begin
			rsp_valid_d = 1'b1;
			rsp_rdata_d = rd_word;
		end
		req_ready_d = state_d == ST_IDLE;
		core_wr = state_q == ST_ACCESS && lat_write_q && lat_core_q && !lat_hole_q;
	end

	// ----------------------------------------------------------------
	// Core registers and program counter
	// ----------------------------------------------------------------
	always_comb begin
		bank_selector_d = bank_selector_q;
		ptr0_d   = ptr0_q;
		ptr1_d   = ptr1_q;
		pclath_d = pclath_q;
		intctl_d = intctl_q;
		acc_d    = acc_q;
		status_d = status_q;
		pc_d     = pc_q;
		if (core_wr) begin
			case (lat_file_q)
				A_STATUS: begin
					if (!lat_flags_q) begin
						status_d = (status_q & ~STATUS_SWMSK) | (lat_wdata_q & STATUS_SWMSK);
					end
				end
				A_P0L:     ptr0_d[7:0] = lat_wdata_q;
				A_P0H:     ptr0_d[PTR_W-1:8] = lat_wdata_q;
				A_P1L:     ptr1_d[7:0] = lat_wdata_q;
				A_P1H:     ptr1_d[PTR_W-1:8] = lat_wdata_q;
				A_BANK:    bank_selector_d = lat_wdata_q[BANK_W-1:0];
				A_ACC:     acc_d = lat_wdata_q;
				A_PCLATCH: pclath_d = lat_wdata_q;
				A_INTCTL:  intctl_d = lat_wdata_q;
				default:   acc_d = acc_q;
			endcase
		end
		if (fin && !lat_write_q && lat_acc_q) begin
			acc_d = rsp_rdata_d;
		end
		if (fin && lat_flags_q) begin
			status_d[ST_Z]  = flag_zero;
			status_d[ST_DC] = nibble_overflow_flag;
			status_d[ST_C]  = flag_carry;
		end
		if (wdt_clear) begin
			status_d[ST_WDT]   = 1'b1;
			status_d[ST_SLEEP] = 1'b1;
		end
		if (sleep_enter) begin
			status_d[ST_WDT]   = 1'b1;
			status_d[ST_SLEEP] = 1'b0;
		end
		if (wdt_timeout) begin
			status_d[ST_WDT] = 1'b0;
		end
		if (irq_enter) begin
			pc_d = IRQ_VEC;
		end else if (pc_load) begin
			pc_d = pc_load_value;
		end else if (core_wr && lat_file_q == A_PCL) begin
			pc_d = {pclath_q[PC_W-9:0], lat_wdata_q};
		end else if (pc_advance) begin
			pc_d = PC_W'(pc_q + 1'b1);
		end
		if (take && dec_prog && !req_write) begin
			prog_addr_d = wrap_prog(sel_ptr[PC_W-1:0]);
		end else if (state_q != ST_IDLE && lat_prog_q && !lat_write_q) begin
			prog_addr_d = prog_addr_q;
		end else begin
			prog_addr_d = wrap_prog(pc_d);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q         <= ST_IDLE;
			lat_prog_q      <= 1'b0;
			lat_write_q     <= 1'b0;
			lat_core_q      <= 1'b0;
			lat_hole_q      <= 1'b0;
			lat_acc_q       <= 1'b0;
			lat_flags_q     <= 1'b0;
			lat_file_q      <= '0;
			lat_wdata_q     <= 8'h00;
			ram_addr_q      <= '0;
			ram_wdata_q     <= 8'h00;
			ram_we_q        <= 1'b0;
			rsp_valid_q     <= 1'b0;
			rsp_rdata_q     <= 8'h00;
			extra_cycle_q   <= 1'b0;
			req_ready_q     <= 1'b0;
			bank_selector_q <= '0;
			ptr0_q          <= '0;
			ptr1_q          <= '0;
			pclath_q        <= 8'h00;
			intctl_q        <= 8'h00;
			acc_q           <= 8'h00;
			status_q        <= STATUS_RST;
			pc_q            <= RESET_VEC;
			prog_addr_q     <= RESET_VEC;
		end else begin
			state_q         <= state_d;
			lat_prog_q      <= lat_prog_d;
			lat_write_q     <= lat_write_d;
			lat_core_q      <= lat_core_d;
			lat_hole_q      <= lat_hole_d;
			lat_acc_q       <= lat_acc_d;
			lat_flags_q     <= lat_flags_d;
			lat_file_q      <= lat_file_d;
			lat_wdata_q     <= lat_wdata_d;
			ram_addr_q      <= ram_addr_d;
			ram_wdata_q     <= ram_wdata_d;
			ram_we_q        <= ram_we_d;
			rsp_valid_q     <= rsp_valid_d;
			rsp_rdata_q     <= rsp_rdata_d;
			extra_cycle_q   <= extra_cycle_d;
			req_ready_q     <= req_ready_d;
			bank_selector_q <= bank_selector_d;
			ptr0_q          <= ptr0_d;
			ptr1_q          <= ptr1_d;
			pclath_q        <= pclath_d;
			intctl_q        <= intctl_d;
			acc_q           <= acc_d;
			status_q        <= status_d;
			pc_q            <= pc_d;
			prog_addr_q     <= prog_addr_d;
		end
	end

endmodule : cpu_memory_bank_mapper

/* design/mem_map_pkg.sv */
// Constants shared by the data memory mapper and its register slave.
// Assumes a single 100 MHz core clock and an active-low asynchronous reset.
package mem_map_pkg;

	localparam int BANK_W  = 5;
	localparam int FILE_W  = 7;
	localparam int DATA_W  = 8;
	localparam int PC_W    = 15;
	localparam int PWORD_W = 14;
	localparam int RAM_AW  = BANK_W + FILE_W;
	localparam int PTR_W   = 16;

	// Bank partitioning: 32 banks of 128 bytes.
	localparam int          BANK_COUNT   = 32;
	localparam int          BANK_BYTES   = 128;
	localparam logic [6:0]  CORE_LAST    = 7'h0b;
	localparam logic [6:0]  GPR_FIRST    = 7'h20;
	localparam logic [6:0]  COMMON_FIRST = 7'h70;
	localparam logic [4:0]  COMMON_BANK  = 5'h00;

	// Core register file addresses, the same in every bank.
	localparam logic [6:0] A_IND0    = 7'h00;
	localparam logic [6:0] A_IND1    = 7'h01;
	localparam logic [6:0] A_PCL     = 7'h02;
	localparam logic [6:0] A_STATUS  = 7'h03;
	localparam logic [6:0] A_P0L     = 7'h04;
	localparam logic [6:0] A_P0H     = 7'h05;
	localparam logic [6:0] A_P1L     = 7'h06;
	localparam logic [6:0] A_P1H     = 7'h07;
	localparam logic [6:0] A_BANK    = 7'h08;
	localparam logic [6:0] A_ACC     = 7'h09;
	localparam logic [6:0] A_PCLATCH = 7'h0a;
	localparam logic [6:0] A_INTCTL  = 7'h0b;

	// Status register layout.
	localparam int         ST_WDT       = 4;
	localparam int         ST_SLEEP     = 3;
	localparam int         ST_Z         = 2;
	localparam int         ST_DC        = 1;
	localparam int         ST_C         = 0;
	localparam logic [7:0] STATUS_RST   = 8'h18;
	localparam logic [7:0] STATUS_SWMSK = 8'h07;
	localparam logic [7:0] STATUS_IMPL  = 8'h1f;

	// Pointer high byte bit 7 selects program memory.
	localparam int PTR_PROG_BIT = 15;

	localparam logic [14:0] RESET_VEC = 15'h0000;
	localparam logic [14:0] IRQ_VEC   = 15'h0004;

	// Register bus map.
	localparam int         AXI_AW     = 8;
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_BANK   = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_PC     = 8'h0c;
	localparam logic [7:0] REG_PTR    = 8'h10;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_PROG_EXTRA} acc_state_t;

endpackage : mem_map_pkg

/* design/mapper_axil_regs.sv */
// AXI4-Lite slave holding the mapper's control word and its state views.
// Assumes one master with at most one write and one read outstanding.
`timescale 1ns/1ps
module mapper_axil_regs #(
	parameter logic [4:0] TOP_BANK_RST = 5'h1f
) (
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	input  wire logic                          awvalid,
	input  wire logic [mem_map_pkg::AXI_AW-1:0] awaddr,
	output logic                               awready,
	input  wire logic                          wvalid,
	input  wire logic [31:0]                   wdata,
	input  wire logic [3:0]                    wstrb,
	output logic                               wready,
	output logic                               bvalid,
	output logic [1:0]                         bresp,
	input  wire logic                          bready,
	input  wire logic                          arvalid,
	input  wire logic [mem_map_pkg::AXI_AW-1:0] araddr,
	output logic                               arready,
	output logic                               rvalid,
	output logic [31:0]                        rdata,
	output logic [1:0]                         rresp,
	input  wire logic                          rready,
	input  wire logic [4:0]                    bank_view,
	input  wire logic [7:0]                    status_view,
	input  wire logic [14:0]                   pc_view,
	input  wire logic [31:0]                   ptr_view,
	output logic [4:0]                         top_bank
);
	import mem_map_pkg::*;

	logic              aw_held_q, aw_held_d, w_held_q, w_held_d;
	logic [AXI_AW-1:0] awaddr_q, awaddr_d;
	logic [31:0]       wdata_q, wdata_d, rdata_d;
	logic              wstrb0_q, wstrb0_d;
	logic              awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
	logic [1:0]        bresp_d, rresp_d;
	logic [4:0]        top_bank_d;

	function automatic logic known(input logic [AXI_AW-1:0] a);
		return a == REG_CTRL || a == REG_BANK || a == REG_STATUS || a == REG_PC || a == REG_PTR;
	endfunction : known

	// ----------------------------------------------------------------
	// Write and read channels
	// ----------------------------------------------------------------
	always_comb begin
		aw_held_d  = aw_held_q;
		w_held_d   = w_held_q;
		awaddr_d   = awaddr_q;
		wdata_d    = wdata_q;
		wstrb0_d   = wstrb0_q;
		bvalid_d   = bvalid && !bready;
		bresp_d    = bresp;
		top_bank_d = top_bank;
		rvalid_d   = rvalid && !rready;
		rdata_d    = rdata;
		rresp_d    = rresp;
		if (aw_held_q && w_held_q && !bvalid) begin
			aw_held_d = 1'b0;
			w_held_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = known(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
			if (awaddr_q == REG_CTRL && wstrb0_q) begin
				top_bank_d = wdata_q[BANK_W-1:0];
			end
		end
		if (awvalid && awready) begin
			aw_held_d = 1'b1;
			awaddr_d  = awaddr;
		end
		if (wvalid && wready) begin
			w_held_d = 1'b1;
			wdata_d  = wdata;
			wstrb0_d = wstrb[0];
		end
		if (arvalid && arready) begin
			rvalid_d = 1'b1;
			rresp_d  = known(araddr) ? RESP_OKAY : RESP_SLVERR;
			case (araddr)
				REG_CTRL:   rdata_d = {27'h0, top_bank};
				REG_BANK:   rdata_d = {27'h0, bank_view};
				REG_STATUS: rdata_d = {24'h0, status_view};
				REG_PC:     rdata_d = {17'h0, pc_view};
				REG_PTR:    rdata_d = ptr_view;
				default:    rdata_d = 32'h0;
			endcase
		end
		awready_d = !aw_held_d;
		wready_d  = !w_held_d;
		arready_d = !rvalid_d;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			awaddr_q  <= '0;
			wdata_q   <= 32'h0;
			wstrb0_q  <= 1'b0;
			awready   <= 1'b0;
			wready    <= 1'b0;
			bvalid    <= 1'b0;
			bresp     <= RESP_OKAY;
			arready   <= 1'b0;
			rvalid    <= 1'b0;
			rdata     <= 32'h0;
			rresp     <= RESP_OKAY;
			top_bank  <= TOP_BANK_RST;
		end else begin
			aw_held_q <= aw_held_d;
			w_held_q  <= w_held_d;
			awaddr_q  <= awaddr_d;
			wdata_q   <= wdata_d;
			wstrb0_q  <= wstrb0_d;
			awready   <= awready_d;
			wready    <= wready_d;
			bvalid    <= bvalid_d;
			bresp     <= bresp_d;
			arready   <= arready_d;
			rvalid    <= rvalid_d;
			rdata     <= rdata_d;
			rresp     <= rresp_d;
			top_bank  <= top_bank_d;
		end
	end

endmodule : mapper_axil_regs

/* dv/mem_model.sv */
// Program and data arrays at the mapper's far side.
// Assumes combinational reads against the registered addresses.
`timescale 1ns/1ps
module mem_model (
	input  wire logic        clk,
	input  wire logic [14:0] prog_addr_q,
	output logic      [13:0] prog_rdata,
	input  wire logic [11:0] ram_addr_q,
	input  wire logic        ram_we_q,
	input  wire logic [7:0]  ram_wdata_q,
	output logic      [7:0]  ram_rdata
);
	logic [7:0] ram [4096];
	initial foreach (ram[i]) ram[i] = 8'h00;
	// Program words follow the address, so a wrong fetch address shows.
	assign prog_rdata = 14'(prog_addr_q * 7 + 3);
	assign ram_rdata = ram[ram_addr_q];
	always @(posedge clk) if (ram_we_q) ram[ram_addr_q] <= ram_wdata_q;
endmodule : mem_model

/* dv/mapper_asserts.sv */
// Checker for request timing, status protection and program counter moves.
// Assumes it is bound into cpu_memory_bank_mapper on its single clock.
`timescale 1ns/1ps
module mapper_chk
	import mem_map_pkg::*;
#(
	parameter int PROG_AW = 12
) (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        req_valid,
	input wire logic        req_write,
	input wire logic        req_indirect,
	input wire logic        req_ready_q,
	input wire logic        rsp_valid_q,
	input wire logic        extra_cycle_q,
	input wire logic        ram_we_q,
	input wire logic [7:0]  status_q,
	input wire logic        pc_advance,
	input wire logic        pc_load,
	input wire logic        irq_enter,
	input wire logic        wdt_timeout,
	input wire logic        wdt_clear,
	input wire logic        sleep_enter,
	input wire logic [14:0] prog_addr_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire take = req_valid && req_ready_q;
	wire [14:0] mask = 15'((1 << PROG_AW) - 1);
	take_busy_a: assert property (take |=> !req_ready_q)
		else $error("ready stayed high after a take");
	direct_rsp_a: assert property (take && !req_indirect |-> ##2 rsp_valid_q)
		else $error("direct access not answered in two cycles");
	extra_rsp_a: assert property (extra_cycle_q |=> rsp_valid_q && !extra_cycle_q)
		else $error("stall cycle not followed by answer");
	prog_read_a: assert property (
		extra_cycle_q |-> $past(req_indirect, 2) && !$past(req_write, 2))
		else $error("stall cycle without indirect read");
	ram_write_a: assert property (ram_we_q |-> $past(take && req_write))
		else $error("stray data write");
	flag_hold_a: assert property (
		!$past(wdt_timeout || wdt_clear || sleep_enter) |-> $stable(status_q[4:3]))
		else $error("protected flags changed");
	wdt_flag_a: assert property (wdt_timeout |=> !status_q[4])
		else $error("timeout flag not cleared");
	sleep_flag_a: assert property (
		sleep_enter && !wdt_timeout |=> status_q[4:3] == 2'b10)
		else $error("sleep flags wrong");
	irq_vec_a: assert property (
		irq_enter && !req_valid && req_ready_q |=> prog_addr_q == IRQ_VEC)
		else $error("interrupt vector wrong");
	pc_step_a: assert property (
		pc_advance && !pc_load && !irq_enter && !req_valid && req_ready_q && $past(req_ready_q)
		|=> prog_addr_q == (($past(prog_addr_q) + 15'h1) & mask))
		else $error("program address step wrong");
endmodule : mapper_chk

bind cpu_memory_bank_mapper mapper_chk #(.PROG_AW(PROG_AW)) i_chk (.*);

/* dv/cpu_memory_bank_mapper_tb.sv */
// Bench driving CPU requests and AXI4-Lite register accesses.
// Assumes mem_model stands for the program and data arrays.
`timescale 1ns/1ps
module cpu_memory_bank_mapper_tb;
	import mem_map_pkg::*;
	logic clk, rst_n, req_valid, req_write, req_indirect, req_ptr_sel, req_load_acc;
	logic req_flags_own, flag_zero, nibble_overflow_flag, flag_carry, req_ready_q;
	logic rsp_valid_q, extra_cycle_q, pc_advance, pc_load, irq_enter, wdt_timeout;
	logic wdt_clear, sleep_enter, ram_we_q, awvalid, awready, wvalid, wready, bvalid;
	logic bready, arvalid, arready, rvalid, rready;
	logic [6:0]  req_file_addr;
	logic [7:0]  req_wdata, rsp_rdata_q, acc_q, status_q, ram_wdata_q, ram_rdata, awaddr, araddr;
	logic [14:0] pc_load_value, prog_addr_q;
	logic [13:0] prog_rdata;
	logic [11:0] ram_addr_q;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	int          n_mismatch, tests_run, nwait;
	logic [22:0] ev_exp [6] = '{23'h40000, 23'hc0000, 23'h80000, 23'h80004, 23'h80fff, 23'h80000};
	cpu_memory_bank_mapper i_dut (.*);
	mem_model i_mem (.*);
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	task automatic tally_and_finish();
		if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : tally_and_finish
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic await(ref logic s);
		nwait = 0;
		do begin
			@(posedge clk);
			nwait++;
		end while (s !== 1'b1 && nwait < 60);
		if (s !== 1'b1) begin
			n_mismatch++;
			tally_and_finish();
		end
	endtask : await
	task automatic cpu(input logic w, i, p, l, f, input logic [6:0] a, input logic [7:0] d);
		{req_write, req_indirect, req_ptr_sel, req_load_acc, req_flags_own} <= {w, i, p, l, f};
		req_file_addr <= a;
		req_wdata <= d;
		req_valid <= 1;
		await(req_ready_q);
		req_valid <= 0;
		await(rsp_valid_q);
		rd = 32'(rsp_rdata_q);
	endtask : cpu
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		fork
			begin
				await(awready);
				awvalid <= 0;
			end
			begin
				await(wready);
				wvalid <= 0;
			end
		join
		await(bvalid);
		bready <= 0;
		rd = 32'(bresp);
	endtask : axw
	task automatic axr(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		await(arready);
		arvalid <= 0;
		await(rvalid);
		rready <= 0;
		rd = rdata;
	endtask : axr
	initial begin
		{req_valid, req_write, req_indirect, req_ptr_sel, req_load_acc, req_flags_own} = '0;
		{flag_zero, nibble_overflow_flag, flag_carry, pc_advance, pc_load, irq_enter} = '0;
		{wdt_timeout, wdt_clear, sleep_enter, awvalid, wvalid, bready, arvalid, rready} = '0;
		{req_file_addr, req_wdata, awaddr, araddr, wdata, wstrb} = '0;
		pc_load_value = 15'h7fff;
		n_mismatch = 0;
		tests_run = 0;
		rst_n = 0;
		repeat (6) @(posedge clk);
		check(status_q, 8'h18);
		check(prog_addr_q, RESET_VEC);
		rst_n <= 1;
		cpu(1, 0, 0, 0, 0, A_BANK, 8'h05);
		axr(REG_BANK);
		check(rd, 32'h5);
		cpu(1, 0, 0, 0, 0, 7'h25, 8'ha5);
		cpu(1, 0, 0, 0, 0, 7'h72, 8'h3c);
		cpu(1, 0, 0, 0, 0, A_ACC, 8'h77);
		cpu(1, 0, 0, 0, 0, A_BANK, 8'h03);
		cpu(0, 0, 0, 0, 0, 7'h25, 8'h0);
		check(rd, 32'h0);
		cpu(0, 0, 0, 0, 0, 7'h72, 8'h0);
		check(rd, 32'h3c);
		cpu(0, 0, 0, 0, 0, A_ACC, 8'h0);
		check(rd, 32'h77);
		check(nwait, 2);
		for (int p = 0; p < 2; p++) begin
			cpu(1, 0, 0, 0, 0, 7'(A_P0L + 2 * p), 8'ha5);
			cpu(1, 0, 0, 0, 0, 7'(A_P0H + 2 * p), 8'h02);
			cpu(0, 1, p[0], 0, 0, 7'h0, 8'h0);
			check(rd, 32'ha5);
		end
		cpu(1, 0, 0, 0, 0, A_P1H, 8'h90);
		cpu(1, 0, 0, 0, 0, A_P1L, 8'h25);
		cpu(0, 1, 1, 1, 0, 7'h0, 8'h0);
		check(rd, 32'h06);
		check(nwait, 3);
		check(acc_q, 8'h06);
		cpu(1, 1, 1, 0, 0, 7'h0, 8'hee);
		check(i_mem.ram[12'h025], 8'h00);
		cpu(1, 0, 0, 0, 0, A_BANK, 8'h05);
		axw(REG_CTRL, 32'h2);
		check(rd, RESP_OKAY);
		cpu(0, 0, 0, 0, 0, 7'h25, 8'h0);
		check(rd, 32'h0);
		axw(REG_CTRL, 32'h1f);
		cpu(0, 0, 0, 0, 0, 7'h25, 8'h0);
		check(rd, 32'ha5);
		axr(8'h40);
		check(rresp, RESP_SLVERR);
		{flag_zero, nibble_overflow_flag, flag_carry} <= 3'b010;
		cpu(1, 0, 0, 0, 1, A_STATUS, 8'hff);
		@(posedge clk);
		check(status_q, 8'h1a);
		cpu(1, 0, 0, 0, 0, A_STATUS, 8'h00);
		@(posedge clk);
		check(status_q, 8'h18);
		for (int k = 0; k < 6; k++) begin
			{wdt_timeout, wdt_clear, sleep_enter, irq_enter, pc_load, pc_advance} <= 6'h20 >> k;
			@(posedge clk);
			{wdt_timeout, wdt_clear, sleep_enter, irq_enter, pc_load, pc_advance} <= 6'h0;
			@(posedge clk);
			check({status_q, prog_addr_q}, ev_exp[k]);
		end
		cpu(1, 0, 0, 0, 0, A_PCLATCH, 8'h12);
		cpu(1, 0, 0, 0, 0, A_PCL, 8'h34);
		check(prog_addr_q, 15'h234);
		axr(REG_PC);
		check(rd, 32'h1234);
		axr(REG_PTR);
		check(rd, 32'h902502a5);
		tally_and_finish();
	end
endmodule : cpu_memory_bank_mapper_tb
